// [rtl/bert_err_inj.sv]
// error injection engine: mode stepping, decade rate counter, external trigger
`timescale 1ns/1ps
`default_nettype none
module bert_err_inj #(
    parameter int PERIOD_E4 = bert_pkg::BERT_PERIOD_E4,
    parameter int PERIOD_E5 = bert_pkg::BERT_PERIOD_E5,
    parameter int PERIOD_E6 = bert_pkg::BERT_PERIOD_E6,
    parameter int PERIOD_E7 = bert_pkg::BERT_PERIOD_E7
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // commands, one-cycle pulses
    input wire logic rate_cmd_in,
    input wire logic single_cmd_in,
    // external trigger pin, asynchronous
    input wire logic ext_trig_in,
    // results
    output logic inject_out,
    output bert_pkg::bert_mode_e mode_out,
    output logic suspended_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [23:0] bert_period(input bert_pkg::bert_mode_e m);
        logic [23:0] p;
        p = 24'(bert_pkg::BERT_PERIOD_E3);
        case (m)
            bert_pkg::BERT_MODE_E7: p = 24'(PERIOD_E7);
            bert_pkg::BERT_MODE_E6: p = 24'(PERIOD_E6);
            bert_pkg::BERT_MODE_E5: p = 24'(PERIOD_E5);
            bert_pkg::BERT_MODE_E4: p = 24'(PERIOD_E4);
            default: p = 24'(bert_pkg::BERT_PERIOD_E3);
        endcase
        return p;
    endfunction : bert_period

    function automatic bert_pkg::bert_mode_e bert_next_mode(input bert_pkg::bert_mode_e m);
        bert_pkg::bert_mode_e n;
        n = bert_pkg::BERT_MODE_SINGLE;
        case (m)
            bert_pkg::BERT_MODE_SINGLE: n = bert_pkg::BERT_MODE_E7;
            bert_pkg::BERT_MODE_E7: n = bert_pkg::BERT_MODE_E6;
            bert_pkg::BERT_MODE_E6: n = bert_pkg::BERT_MODE_E5;
            bert_pkg::BERT_MODE_E5: n = bert_pkg::BERT_MODE_E4;
            bert_pkg::BERT_MODE_E4: n = bert_pkg::BERT_MODE_E3;
            bert_pkg::BERT_MODE_E3: n = bert_pkg::BERT_MODE_EXT;
            default: n = bert_pkg::BERT_MODE_SINGLE;
        endcase
        return n;
    endfunction : bert_next_mode

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    bert_pkg::bert_inj_state_s st;
    bert_pkg::bert_inj_state_s next_st;

    always_comb
    begin
        logic internal;
        logic running;
        logic rate_tick;
        logic ext_edge;
        internal = 1'b0;
        running = 1'b0;
        rate_tick = 1'b0;
        ext_edge = 1'b0;
        next_st = st;
        next_st.trig_sync1 = ext_trig_in;
        next_st.trig_sync2 = st.trig_sync1;
        next_st.trig_prev = st.trig_sync2;
        running = (st.mode != bert_pkg::BERT_MODE_SINGLE) && !st.suspended;
        internal = running && (st.mode != bert_pkg::BERT_MODE_EXT);
        // trigger is watched only while external mode runs
        ext_edge = running && (st.mode == bert_pkg::BERT_MODE_EXT)
            && st.trig_sync2 && !st.trig_prev;
        // one error per period of ten to the n bits
        if (internal)
        begin
            if (st.bit_cnt >= bert_period(st.mode) - bert_pkg::BERT_RATE_STEP)
            begin
                next_st.bit_cnt = '0;
                rate_tick = 1'b1;
            end
            else
            begin
                next_st.bit_cnt = st.bit_cnt + bert_pkg::BERT_RATE_STEP;
            end
        end
        else
        begin
            next_st.bit_cnt = '0;
        end
        // a coincident single command and rate tick merge into one error
        next_st.inject = single_cmd_in || rate_tick || ext_edge;
        if (rate_cmd_in)
        begin
            if (st.suspended)
            begin
                next_st.suspended = 1'b0;
            end
            else
            begin
                next_st.mode = bert_next_mode(st.mode);
                next_st.bit_cnt = '0;
            end
        end
        else if (single_cmd_in && (st.mode != bert_pkg::BERT_MODE_SINGLE))
        begin
            next_st.suspended = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign inject_out = st.inject;
    assign mode_out = st.mode;
    assign suspended_out = st.suspended;

endmodule : bert_err_inj
`default_nettype wire

// [rtl/bert_pkg.sv]
// constants, enums and state structs of the transmit output and error-inject block
package bert_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] BERT_OFS_CMD = 12'h000;
    localparam logic [11:0] BERT_OFS_CFG = 12'h004;
    localparam logic [11:0] BERT_OFS_STATUS = 12'h008;
    localparam logic [11:0] BERT_OFS_ERRCNT = 12'h00c;

    // command word bits, each a self-clearing pulse
    localparam int BERT_CMD_INVERT_BIT = 0;
    localparam int BERT_CMD_RATE_BIT = 1;
    localparam int BERT_CMD_SINGLE_BIT = 2;

    // config word field
    localparam int BERT_CFG_PAT_LSB = 0;
    localparam int BERT_CFG_PAT_MSB = 1;

    // status word fields
    localparam int BERT_ST_INV_BIT = 0;
    localparam int BERT_ST_ACTIVE_BIT = 1;
    localparam int BERT_ST_MODE_LSB = 2;
    localparam int BERT_ST_MODE_MSB = 4;
    localparam int BERT_ST_SUSP_BIT = 5;

    // ------------------------------------------------------------------
    // pattern framing and counter steps
    // ------------------------------------------------------------------
    localparam logic [3:0] BERT_POS_FIRST = 4'h0;
    localparam logic [3:0] BERT_POS_NEXT = 4'h1;
    localparam logic [3:0] BERT_POS_LAST = 4'hf;
    localparam logic [3:0] BERT_BYTE_BITS = 4'h8;
    localparam logic [1:0] BERT_DIV4_STEP = 2'h1;
    localparam logic [15:0] BERT_ERRCNT_STEP = 16'h0001;
    localparam logic [23:0] BERT_RATE_STEP = 24'h000001;

    // bits per injected error at each internal decade
    localparam int BERT_PERIOD_E3 = 1000;
    localparam int BERT_PERIOD_E4 = 10000;
    localparam int BERT_PERIOD_E5 = 100000;
    localparam int BERT_PERIOD_E6 = 1000000;
    localparam int BERT_PERIOD_E7 = 10000000;

    typedef enum logic [1:0] {
        BERT_PAT_PRBS = 2'b00,
        BERT_PAT_SHORT_WORD = 2'b01,
        BERT_PAT_LONG_WORD = 2'b10
    } bert_pat_e;

    typedef enum logic [2:0] {
        BERT_MODE_SINGLE = 3'b000,
        BERT_MODE_E7 = 3'b001,
        BERT_MODE_E6 = 3'b010,
        BERT_MODE_E5 = 3'b011,
        BERT_MODE_E4 = 3'b100,
        BERT_MODE_E3 = 3'b101,
        BERT_MODE_EXT = 3'b110
    } bert_mode_e;

    // ------------------------------------------------------------------
    // state records
    // ------------------------------------------------------------------
    typedef struct packed {
        logic trig_sync1;
        logic trig_sync2;
        logic trig_prev;
        bert_mode_e mode;
        logic suspended;
        logic [23:0] bit_cnt;
        logic inject;
    } bert_inj_state_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic cmd_rate;
        logic cmd_single;
        logic data_invert_enable;
        bert_pat_e pat_type;
        logic [3:0] pat_pos;
        logic data;
        logic data_n;
        logic frame_sync;
        logic err_flag;
        logic rate_active;
        logic [15:0] err_count;
        logic clk_pos_toggle;
    } bert_top_state_s;

    typedef struct packed {
        logic clk_neg_toggle;
        logic [1:0] div4_cnt;
        logic div4;
        logic div4_n;
    } bert_neg_state_s;

endpackage : bert_pkg

// [rtl/bert_tx_out.sv]
// transmit output stage: inversion, error insertion, clocks, frame sync, apb registers
`timescale 1ns/1ps
`default_nettype none
module bert_tx_out #(
    parameter int PERIOD_E4 = bert_pkg::BERT_PERIOD_E4,
    parameter int PERIOD_E5 = bert_pkg::BERT_PERIOD_E5,
    parameter int PERIOD_E6 = bert_pkg::BERT_PERIOD_E6,
    parameter int PERIOD_E7 = bert_pkg::BERT_PERIOD_E7
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [31:0] prdata_out,
    // pattern stream from the generator, same clock
    input wire logic pat_data_in,
    input wire logic pat_frame_start_in,
    // external error trigger pin
    input wire logic ext_trig_in,
    // line outputs
    output logic data_out,
    output logic data_n_out,
    output logic clk_out,
    output logic clk_n_out,
    output logic clk_div4_out,
    output logic frame_sync_out,
    // indicators
    output logic err_injected_out,
    output logic rate_active_out
);

    // ------------------------------------------------------------------
    // error injection engine
    // ------------------------------------------------------------------
    bert_pkg::bert_top_state_s st;
    bert_pkg::bert_top_state_s next_st;
    bert_pkg::bert_neg_state_s nst;
    bert_pkg::bert_neg_state_s next_nst;
    logic inject;
    bert_pkg::bert_mode_e mode;
    logic suspended;

    bert_err_inj #(
        .PERIOD_E4(PERIOD_E4),
        .PERIOD_E5(PERIOD_E5),
        .PERIOD_E6(PERIOD_E6),
        .PERIOD_E7(PERIOD_E7)
    ) u_err_inj (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .rate_cmd_in(st.cmd_rate),
        .single_cmd_in(st.cmd_single),
        .ext_trig_in(ext_trig_in),
        .inject_out(inject),
        .mode_out(mode),
        .suspended_out(suspended)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] bert_status(input logic inv, input logic act,
                                                input bert_pkg::bert_mode_e m,
                                                input logic susp);
        logic [31:0] w;
        w = '0;
        w[bert_pkg::BERT_ST_INV_BIT] = inv;
        w[bert_pkg::BERT_ST_ACTIVE_BIT] = act;
        w[bert_pkg::BERT_ST_MODE_MSB:bert_pkg::BERT_ST_MODE_LSB] = m;
        w[bert_pkg::BERT_ST_SUSP_BIT] = susp;
        return w;
    endfunction : bert_status

    // ------------------------------------------------------------------
    // rising-edge logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic setup;
        logic wr_take;
        logic [3:0] pos;
        logic bit_out;
        logic sync;
        setup = 1'b0;
        wr_take = 1'b0;
        pos = '0;
        bit_out = 1'b0;
        sync = 1'b0;
        next_st = st;

        // zero-wait slave: ready in the first access cycle
        setup = psel_in && !penable_in && !st.pready;
        wr_take = psel_in && penable_in && st.pready && pwrite_in;
        next_st.pready = setup;
        next_st.cmd_rate = 1'b0;
        next_st.cmd_single = 1'b0;
        if (setup)
        begin
            next_st.pslverr = 1'b0;
            next_st.prdata = '0;
            if (paddr_in == bert_pkg::BERT_OFS_CMD)
            begin
                next_st.prdata = '0;
            end
            else if (paddr_in == bert_pkg::BERT_OFS_CFG)
            begin
                next_st.prdata[bert_pkg::BERT_CFG_PAT_MSB:bert_pkg::BERT_CFG_PAT_LSB] =
                    st.pat_type;
            end
            else if (paddr_in == bert_pkg::BERT_OFS_STATUS)
            begin
                next_st.prdata = bert_status(st.data_invert_enable, st.rate_active,
                                             mode, suspended);
            end
            else if (paddr_in == bert_pkg::BERT_OFS_ERRCNT)
            begin
                next_st.prdata = 32'(st.err_count);
            end
            else
            begin
                next_st.pslverr = 1'b1;
            end
        end
        else if (!psel_in)
        begin
            next_st.pslverr = 1'b0;
            next_st.prdata = '0;
        end
        if (wr_take && (paddr_in == bert_pkg::BERT_OFS_CMD))
        begin
            if (pwdata_in[bert_pkg::BERT_CMD_INVERT_BIT])
            begin
                next_st.data_invert_enable = !st.data_invert_enable;
            end
            next_st.cmd_rate = pwdata_in[bert_pkg::BERT_CMD_RATE_BIT];
            next_st.cmd_single = pwdata_in[bert_pkg::BERT_CMD_SINGLE_BIT];
        end
        else if (wr_take && (paddr_in == bert_pkg::BERT_OFS_CFG))
        begin
            next_st.pat_type = bert_pkg::bert_pat_e'(
                pwdata_in[bert_pkg::BERT_CFG_PAT_MSB:bert_pkg::BERT_CFG_PAT_LSB]);
        end

        // data path: inversion first, error on top of it
        bit_out = pat_data_in ^ st.data_invert_enable ^ inject;
        next_st.data = bit_out;
        next_st.data_n = !bit_out;

        // bit position within frame; long words saturate so sync stays low
        pos = pat_frame_start_in ? bert_pkg::BERT_POS_FIRST : st.pat_pos;
        if (pat_frame_start_in)
        begin
            next_st.pat_pos = bert_pkg::BERT_POS_NEXT;
        end
        else if ((st.pat_type == bert_pkg::BERT_PAT_LONG_WORD)
                 && (st.pat_pos == bert_pkg::BERT_POS_LAST))
        begin
            next_st.pat_pos = bert_pkg::BERT_POS_LAST;
        end
        else
        begin
            next_st.pat_pos = st.pat_pos + bert_pkg::BERT_POS_NEXT;
        end
        case (st.pat_type)
            bert_pkg::BERT_PAT_SHORT_WORD: sync = pos < bert_pkg::BERT_BYTE_BITS;
            bert_pkg::BERT_PAT_LONG_WORD: sync = pos < bert_pkg::BERT_BYTE_BITS;
            default: sync = pat_frame_start_in;
        endcase
        next_st.frame_sync = sync;

        next_st.err_flag = inject;
        if (inject)
        begin
            next_st.err_count = st.err_count + bert_pkg::BERT_ERRCNT_STEP;
        end
        next_st.rate_active = mode != bert_pkg::BERT_MODE_SINGLE;
        next_st.clk_pos_toggle = !st.clk_pos_toggle;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            st <= '{pready: 1'b0, pslverr: 1'b0, prdata: '0, cmd_rate: 1'b0,
                    cmd_single: 1'b0, data_invert_enable: 1'b0,
                    pat_type: bert_pkg::BERT_PAT_PRBS, pat_pos: '0, data: 1'b0,
                    data_n: 1'b1, frame_sync: 1'b0, err_flag: 1'b0,
                    rate_active: 1'b0, err_count: '0, clk_pos_toggle: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // falling-edge logic
    // ------------------------------------------------------------------
    // the quarter-rate clock lives here so its edges sit mid-bit
    always_comb
    begin
        next_nst = nst;
        next_nst.clk_neg_toggle = st.clk_pos_toggle;
        next_nst.div4_cnt = nst.div4_cnt + bert_pkg::BERT_DIV4_STEP;
        next_nst.div4 = nst.div4_cnt[1];
        next_nst.div4_n = !nst.div4_cnt[1];
    end

    always_ff @(negedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            nst <= '{clk_neg_toggle: 1'b0, div4_cnt: '0, div4: 1'b0, div4_n: 1'b1};
        end
        else
        begin
            nst <= next_nst;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign pready_out = st.pready;
    assign pslverr_out = st.pslverr;
    assign prdata_out = st.prdata;
    assign data_out = st.data;
    assign data_n_out = st.data_n;
    // forwarded bit clock: toggle pair, high in the first half of each bit
    assign clk_out = st.clk_pos_toggle ^ nst.clk_neg_toggle;
    assign clk_n_out = !(st.clk_pos_toggle ^ nst.clk_neg_toggle);
    assign clk_div4_out = nst.div4;
    assign frame_sync_out = st.frame_sync;
    assign err_injected_out = st.err_flag;
    assign rate_active_out = st.rate_active;

endmodule : bert_tx_out
`default_nettype wire

// [sim/bert_rx_model.sv]
// receiving device model: takes serial data and sync on the falling line clock
`timescale 1ns/1ps
`default_nettype none
module bert_rx_model (
    // line inputs
    input wire logic clk_in,
    input wire logic data_in,
    input wire logic data_n_in,
    input wire logic sync_in,
    // captured values
    output logic rx_data_out,
    output logic rx_sync_out,
    output logic pair_bad_out
);
    // mid-bit capture keeps clear of the launch edge
    always_ff @(negedge clk_in)
    begin
        rx_data_out <= data_in;
        rx_sync_out <= sync_in;
        pair_bad_out <= data_n_in == data_in;
    end
endmodule : bert_rx_model
`default_nettype wire

// [sim/bert_tx_out_properties.sv]
// assertion checker for the transmit output and error-inject stage
`timescale 1ns/1ps
`default_nettype none
module bert_tx_out_properties (
    // clock, reset and bus
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // stream and line side
    input wire logic pat_frame_start_in,
    input wire logic data_out,
    input wire logic data_n_out,
    input wire logic clk_out,
    input wire logic clk_n_out,
    input wire logic clk_div4_out,
    input wire logic frame_sync_out,
    input wire logic err_injected_out,
    input wire logic rate_active_out
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic [3:0] since_cmd;
    logic div4_at_pos, cmd_wr;
    assign cmd_wr = psel_in && penable_in && pready_out && pwrite_in
        && paddr_in == bert_pkg::BERT_OFS_CMD;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // saturating age of the last command write
    always_ff @(posedge sys_clk_in)
    begin
        div4_at_pos <= clk_div4_out;
        if (!rst_n_in)
            since_cmd <= 4'hf;
        else if (cmd_wr)
            since_cmd <= 4'h0;
        else if (since_cmd != 4'hf)
            since_cmd <= since_cmd + 4'h1;
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    chk_data_pair: assert property (data_n_out == ~data_out)
        else $error("data pair broken");
    chk_clk_pair: assert property (clk_n_out == ~clk_out)
        else $error("clock pair broken");
    chk_div4_period: assert property (@(negedge sys_clk_in) disable iff (!rst_n_in)
        $changed(clk_div4_out) |=> $stable(clk_div4_out) ##1 $changed(clk_div4_out))
        else $error("div4 period");
    chk_div4_fall: assert property (@(negedge sys_clk_in) disable iff (!rst_n_in)
        clk_div4_out == div4_at_pos)
        else $error("div4 off falling edge");
    chk_sync_start: assert property (pat_frame_start_in |=> frame_sync_out)
        else $error("no frame sync");
    chk_err_pulse: assert property (err_injected_out |=> !err_injected_out)
        else $error("inject flag too wide");
    chk_single_cmd: assert property (cmd_wr && pwdata_in[bert_pkg::BERT_CMD_SINGLE_BIT]
        |-> ##[1:5] err_injected_out)
        else $error("single error missing");
    chk_quiet_single: assert property ((!rate_active_out && !psel_in)[*6]
        |-> !err_injected_out)
        else $error("unrequested error");
    chk_active_cause: assert property ($changed(rate_active_out) |-> since_cmd < 4'h6)
        else $error("rate indicator moved alone");
    chk_apb_ready: assert property (psel_in && !penable_in |=> pready_out)
        else $error("bus access not answered");
    chk_apb_bad: assert property (psel_in && !penable_in
        && paddr_in > bert_pkg::BERT_OFS_ERRCNT |=> pslverr_out)
        else $error("unmapped access not refused");
    cov_single: cover property (err_injected_out && !rate_active_out);
    cov_rate: cover property (err_injected_out && rate_active_out);
    cov_sync: cover property (pat_frame_start_in ##1 frame_sync_out);
endmodule : bert_tx_out_properties
`default_nettype wire

// [sim/test_bert_tx_output_error_inject.sv]
// self-checking bench for the transmit output and error-inject stage
`timescale 1ns/1ps
`default_nettype none
module test_bert_tx_output_error_inject;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    // short periods keep the decade-rate runs brief
    localparam int PE4 = 20;
    localparam int PE5 = 30;
    localparam int PE6 = 40;
    localparam int PE7 = 50;
    localparam logic [31:0] PATTERN = 32'hc35a1e87;
    localparam logic [11:0] CMD = bert_pkg::BERT_OFS_CMD;
    localparam logic [11:0] CFG = bert_pkg::BERT_OFS_CFG;
    localparam logic [11:0] ST = bert_pkg::BERT_OFS_STATUS;
    localparam logic [11:0] EC = bert_pkg::BERT_OFS_ERRCNT;
    logic sys_clk_in = 1'h0, rst_n_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
    logic pwrite_in = 1'h0, pat_data_in = 1'h0, pat_frame_start_in = 1'h0, ext_trig_in = 1'h0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h00000000;
    logic pready_out, pslverr_out, data_out, data_n_out, clk_out, clk_n_out;
    logic clk_div4_out, frame_sync_out, err_injected_out, rate_active_out;
    logic [31:0] prdata_out, rdv;
    logic rx_data, rx_sync, pair_bad, erv, pat_q, flip, exp_sync;
    logic inv_exp = 1'h0, mon_on = 1'h0;
    logic [4:0] pos = 5'h00, pat_pos = 5'h00, pos_q;
    logic [1:0] sync_type = 2'h0;
    int flips, cnt, err_count = 0, total_checks = 0;
    int per [5] = '{PE7, PE6, PE5, PE4, bert_pkg::BERT_PERIOD_E3};
    bert_tx_out #(.PERIOD_E4(PE4), .PERIOD_E5(PE5), .PERIOD_E6(PE6), .PERIOD_E7(PE7)) dut (.*);
    bert_rx_model rx (.clk_in(clk_out), .data_in(data_out), .data_n_in(data_n_out),
        .sync_in(frame_sync_out), .rx_data_out(rx_data), .rx_sync_out(rx_sync),
        .pair_bad_out(pair_bad));
    // ------------------------------------------------------------------
    // clock, pattern source and line monitor
    // ------------------------------------------------------------------
    initial
    begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in)
    begin
        pos <= pos + 5'h01;
        pat_pos <= pos;
        pat_data_in <= PATTERN[pos];
        pat_frame_start_in <= pos == 5'h00;
        pat_q <= pat_data_in;
        pos_q <= pat_pos;
        if (mon_on)
        begin
            flip = rx_data ^ pat_q ^ inv_exp;
            flips += int'(flip);
            case (sync_type)
                2'h1: exp_sync = ~pos_q[3];
                2'h2: exp_sync = pos_q < 5'h08;
                default: exp_sync = pos_q == 5'h00;
            endcase
            check("inject flag", err_injected_out, flip);
            check("frame sync", rx_sync, exp_sync);
            check("data pair", pair_bad, 1'h0);
        end
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic er);
        int n;
        psel_in <= 1'h1;
        penable_in <= 1'h0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge sys_clk_in);
        penable_in <= 1'h1;
        n = 0;
        do
        begin
            @(posedge sys_clk_in);
            n++;
        end
        while (pready_out !== 1'h1 && n < 20);
        if (pready_out !== 1'h1)
        begin
            err_count++;
            final_report();
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
        @(posedge sys_clk_in);
    endtask : apb
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h00000000, rdv, erv);
        check(name, rdv, exp);
    endtask : rd_chk
    task automatic cmd(input logic [31:0] bits);
        apb(1'h1, CMD, bits, rdv, erv);
        repeat (6) @(posedge sys_clk_in);
    endtask : cmd
    task automatic mon_start();
        flips = 0;
        mon_on <= 1'h1;
    endtask : mon_start
    task automatic mon_stop();
        mon_on <= 1'h0;
        @(posedge sys_clk_in);
    endtask : mon_stop
    task automatic run(input int n);
        mon_start();
        repeat (n) @(posedge sys_clk_in);
        mon_stop();
    endtask : run
    task automatic trig_pulse();
        ext_trig_in <= 1'h1;
        repeat (4) @(posedge sys_clk_in);
        ext_trig_in <= 1'h0;
        // no more than one edge per thousand bits
        repeat (996) @(posedge sys_clk_in);
    endtask : trig_pulse
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'h1;
        @(posedge sys_clk_in);
        rd_chk("status", ST, 32'h00000000);
        rd_chk("errcnt", EC, 32'h00000000);
        apb(1'h1, ST, 32'hffffffff, rdv, erv);
        rd_chk("status ro", ST, 32'h00000000);
        apb(1'h1, 12'h010, 32'h00000001, rdv, erv);
        check("bad write", erv, 1'h1);
        apb(1'h0, 12'h010, 32'h00000000, rdv, erv);
        check("bad read", erv, 1'h1);
        check("bad data", rdv, 32'h00000000);
        $display("test registers done");
        for (int t = 0; t < 3; t++)
        begin
            apb(1'h1, CFG, 32'(t), rdv, erv);
            sync_type = 2'(t);
            repeat (40) @(posedge sys_clk_in);
            run(96);
            check("flips", flips, 0);
            rd_chk("cfg", CFG, 32'(t));
        end
        $display("test frame sync done");
        cmd(32'h00000001);
        inv_exp = 1'h1;
        run(64);
        check("flips", flips, 0);
        rd_chk("status", ST, 32'h00000001);
        cmd(32'h00000001);
        inv_exp = 1'h0;
        rd_chk("status", ST, 32'h00000000);
        $display("test invert done");
        mon_start();
        repeat (3) cmd(32'h00000004);
        trig_pulse();
        trig_pulse();
        mon_stop();
        check("flips", flips, 3);
        rd_chk("errcnt", EC, 32'h00000003);
        $display("test single done");
        for (int m = 1; m <= 5; m++)
        begin
            cmd(32'h00000002);
            rd_chk("status", ST, 32'(m * 4 + 2));
            cnt = (m == 5) ? 3 : 10;
            run(per[m - 1] * cnt);
            check("flips", flips, cnt);
            if (m == 4)
            begin
                cmd(32'h00000004);
                rd_chk("status", ST, 32'h00000032);
                run(200);
                check("flips", flips, 0);
                cmd(32'h00000002);
                rd_chk("status", ST, 32'h00000012);
                run(200);
                check("flips", flips, 10);
            end
        end
        cmd(32'h00000002);
        rd_chk("status", ST, 32'h0000001a);
        mon_start();
        repeat (3) trig_pulse();
        mon_stop();
        check("flips", flips, 3);
        cmd(32'h00000002);
        rd_chk("status", ST, 32'h00000000);
        $display("test rates done");
        final_report();
    end
endmodule : test_bert_tx_output_error_inject
bind bert_tx_out bert_tx_out_properties chk (.*);
`default_nettype wire
